// [rtl/fas_fifo.sv]
// small valid/ready fifo carrying finished conversions
`timescale 1ns/1ps
module fas_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign in_ready_o = cnt_reg < (AW+1)'(DEPTH);
   assign out_valid_o = cnt_reg != '0;
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wr_next = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1) : wr_reg;
      rd_next = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1) : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end
endmodule

// [rtl/fas_pkg.sv]
// shared constants and carrier types of the frame aligned converter sampler
package fas_pkg;
   localparam int RESULT_W = 12;
   localparam int CHAN_W = 5;
   localparam int NUM_CHAN = 32;
   localparam int SLOT_W = 6;
   localparam int MAX_SLOTS = 63;
   localparam logic [CHAN_W-1:0] CH_CURRENT_AMP = 5'h00;
   localparam logic [CHAN_W-1:0] CH_EXT_FIRST = 5'h01;
   localparam logic [CHAN_W-1:0] CH_EXT_LAST = 5'h07;
   localparam logic [CHAN_W-1:0] CH_UNUSED = 5'h1C;
   localparam logic [1:0] GAIN_24X = 2'h0;
   localparam logic [1:0] GAIN_12X = 2'h1;
   localparam logic [1:0] GAIN_9X = 2'h2;
   localparam logic [1:0] GAIN_RESET = GAIN_24X;
   // serial command word: pair, slot index, first channel, second channel, gain
   localparam int CMD_W = 1 + SLOT_W + CHAN_W + CHAN_W + 2;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
   localparam int CONV_CYCLES = 16;
   localparam int FIFO_DEPTH = 4;

   typedef struct packed {
      logic pair;
      logic [SLOT_W-1:0] slot;
      logic [CHAN_W-1:0] chan_a;
      logic [CHAN_W-1:0] chan_b;
      logic [1:0] gain;
   } fas_cmd_s;

   typedef struct packed {
      logic [SLOT_W-1:0] slot;
      logic [RESULT_W-1:0] data;
   } fas_result_s;

   typedef enum logic [1:0] {
      FAS_IDLE,
      FAS_CONV_A,
      FAS_CONV_B
   } fas_conv_e;
endpackage

// [rtl/fas_result_mem.sv]
// working buffer and frame-stable shadow copy of the sample results
`timescale 1ns/1ps
module fas_result_mem #(
   parameter int WIDTH = 12,
   parameter int ENTRIES = 63,
   parameter int AW = 6
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic latch_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] work_reg [ENTRIES];
   logic [WIDTH-1:0] shadow_reg [ENTRIES];
   logic [WIDTH-1:0] rd_reg;

   // whole buffer copies in one edge, so readers never see two frames mixed
   for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            work_reg[i] <= '0;
            shadow_reg[i] <= '0;
         end else begin
            if (wr_en_i && wr_addr_i == AW'(i)) begin
               work_reg[i] <= wr_data_i;
            end
            if (latch_i) begin
               shadow_reg[i] <= work_reg[i];
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_reg <= '0;
      end else if (rd_addr_i < AW'(ENTRIES)) begin
         rd_reg <= shadow_reg[rd_addr_i];
      end else begin
         rd_reg <= '0;
      end
   end
   assign rd_data_o = rd_reg;
endmodule

// [rtl/fas_sampler.sv]
// converter control: serial command link, paired capture, result buffering
`timescale 1ns/1ps
module fas_sampler (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_clk_i,
   input wire logic link_cs_n_i,
   input wire logic link_din_i,
   output logic link_dout_o,
   input wire logic frame_start_i,
   output logic sample_hold_o,
   output logic [1:0] hold_stage_o,
   output logic [fas_pkg::CHAN_W-1:0] mux_sel_o,
   output logic [1:0] amp_gain_o,
   output logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic [fas_pkg::RESULT_W-1:0] conv_data_i,
   input wire logic [fas_pkg::SLOT_W-1:0] rd_addr_i,
   output logic [fas_pkg::RESULT_W-1:0] rd_data_o,
   output logic overrun_o
);
   // pin synchronisers
   logic [1:0] clk_s_reg, cs_s_reg, din_s_reg, fr_s_reg;
   logic clk_d_reg, fr_d_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_s_reg <= 2'h0;
         cs_s_reg <= 2'h3;
         din_s_reg <= 2'h0;
         fr_s_reg <= 2'h0;
         clk_d_reg <= 1'b0;
         fr_d_reg <= 1'b0;
      end else begin
         clk_s_reg <= {clk_s_reg[0], link_clk_i};
         cs_s_reg <= {cs_s_reg[0], link_cs_n_i};
         din_s_reg <= {din_s_reg[0], link_din_i};
         fr_s_reg <= {fr_s_reg[0], frame_start_i};
         clk_d_reg <= clk_s_reg[1];
         fr_d_reg <= fr_s_reg[1];
      end
   end
   logic link_rise, frame_edge;
   assign link_rise = clk_s_reg[1] && !clk_d_reg;
   assign frame_edge = fr_s_reg[1] && !fr_d_reg;

   // serial shift: each framed word is one sample command, result bits go back
   logic [fas_pkg::CMD_W-1:0] sh_reg, sh_next;
   logic [4:0] bit_reg, bit_next;
   logic cmd_stb_reg, cmd_stb_next;
   logic dout_reg, dout_next;
   logic [fas_pkg::RESULT_W-1:0] tx_reg, tx_next;
   logic [fas_pkg::RESULT_W-1:0] rd_data;
   always_comb begin
      sh_next = sh_reg;
      bit_next = bit_reg;
      cmd_stb_next = 1'b0;
      dout_next = dout_reg;
      tx_next = tx_reg;
      if (cs_s_reg[1]) begin
         bit_next = 5'h00;
         tx_next = rd_data;
      end else if (link_rise) begin
         sh_next = {sh_reg[fas_pkg::CMD_W-2:0], din_s_reg[1]};
         dout_next = tx_reg[fas_pkg::RESULT_W-1];
         tx_next = {tx_reg[fas_pkg::RESULT_W-2:0], 1'b0};
         if (bit_reg == 5'(fas_pkg::CMD_W - 1)) begin
            bit_next = 5'h00;
            cmd_stb_next = 1'b1;
         end else begin
            bit_next = bit_reg + 5'h01;
         end
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sh_reg <= '0;
         bit_reg <= 5'h00;
         cmd_stb_reg <= 1'b0;
         dout_reg <= 1'b0;
         tx_reg <= '0;
      end else begin
         sh_reg <= sh_next;
         bit_reg <= bit_next;
         cmd_stb_reg <= cmd_stb_next;
         dout_reg <= dout_next;
         tx_reg <= tx_next;
      end
   end
   fas_pkg::fas_cmd_s cmd;
   assign cmd = fas_pkg::fas_cmd_s'(sh_reg);

   // conversion sequencer: one command per controller-timed instant
   fas_pkg::fas_conv_e st_reg, st_next;
   fas_pkg::fas_cmd_s cur_reg, cur_next;
   logic [1:0] hold_reg, hold_next;
   logic [fas_pkg::CHAN_W-1:0] mux_reg, mux_next;
   logic [1:0] gain_reg, gain_next;
   logic start_reg, start_next;
   logic sh_pulse_reg, sh_pulse_next;
   logic ovr_reg, ovr_next;
   logic push_valid, push_ready;
   fas_pkg::fas_result_s push_data;
   logic accept;
   assign accept = cmd_stb_reg && cmd.slot < 6'(fas_pkg::MAX_SLOTS);
   always_comb begin
      st_next = st_reg;
      cur_next = cur_reg;
      hold_next = hold_reg;
      mux_next = mux_reg;
      gain_next = gain_reg;
      start_next = 1'b0;
      sh_pulse_next = 1'b0;
      ovr_next = ovr_reg;
      push_valid = 1'b0;
      push_data = '{slot: cur_reg.slot, data: conv_data_i};
      unique case (st_reg)
         fas_pkg::FAS_IDLE: begin
            if (accept) begin
               // both stages hold in the same cycle for a pair
               cur_next = cmd;
               sh_pulse_next = 1'b1;
               hold_next = cmd.pair ? 2'h3 : 2'h1;
               mux_next = cmd.chan_a;
               if (cmd.chan_a == fas_pkg::CH_CURRENT_AMP && cmd.gain != 2'h3) begin
                  gain_next = cmd.gain;
               end
               start_next = 1'b1;
               st_next = fas_pkg::FAS_CONV_A;
            end
         end
         fas_pkg::FAS_CONV_A: begin
            if (conv_done_i) begin
               push_valid = 1'b1;
               if (push_ready) begin
                  hold_next = {hold_reg[1], 1'b0};
                  if (cur_reg.pair) begin
                     // second held value converts afterwards
                     mux_next = cur_reg.chan_b;
                     start_next = 1'b1;
                     st_next = fas_pkg::FAS_CONV_B;
                  end else begin
                     st_next = fas_pkg::FAS_IDLE;
                  end
               end
            end
         end
         fas_pkg::FAS_CONV_B: begin
            push_data = '{slot: 6'(cur_reg.slot + 6'h01), data: conv_data_i};
            if (conv_done_i) begin
               push_valid = 1'b1;
               if (push_ready) begin
                  hold_next = 2'h0;
                  st_next = fas_pkg::FAS_IDLE;
               end
            end
         end
      endcase
      // command while busy is dropped; flag until next frame
      if (cmd_stb_reg && st_reg != fas_pkg::FAS_IDLE) begin
         ovr_next = 1'b1;
      end else if (frame_edge) begin
         ovr_next = 1'b0;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= fas_pkg::FAS_IDLE;
         cur_reg <= '0;
         hold_reg <= 2'h0;
         mux_reg <= fas_pkg::CH_CURRENT_AMP;
         gain_reg <= fas_pkg::GAIN_RESET;
         start_reg <= 1'b0;
         sh_pulse_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cur_reg <= cur_next;
         hold_reg <= hold_next;
         mux_reg <= mux_next;
         gain_reg <= gain_next;
         start_reg <= start_next;
         sh_pulse_reg <= sh_pulse_next;
         ovr_reg <= ovr_next;
      end
   end

   // results queue into the working buffer
   logic q_valid;
   fas_pkg::fas_result_s q_data;
   fas_fifo #(
      .WIDTH(fas_pkg::SLOT_W + fas_pkg::RESULT_W),
      .DEPTH(fas_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(push_data),
      .out_valid_o(q_valid),
      .out_ready_i(!frame_edge),
      .out_data_o(q_data)
   );
   logic q_pop;
   // drain paused on the latch edge so it copies a settled buffer
   assign q_pop = q_valid && !frame_edge;

   fas_result_mem #(
      .WIDTH(fas_pkg::RESULT_W),
      .ENTRIES(fas_pkg::MAX_SLOTS),
      .AW(fas_pkg::SLOT_W)
   ) u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(q_pop && q_data.slot < 6'(fas_pkg::MAX_SLOTS)),
      .wr_addr_i(q_data.slot),
      .wr_data_i(q_data.data),
      .latch_i(frame_edge),
      .rd_addr_i(rd_addr_i),
      .rd_data_o(rd_data)
   );

   assign link_dout_o = dout_reg;
   assign sample_hold_o = sh_pulse_reg;
   assign hold_stage_o = hold_reg;
   assign mux_sel_o = mux_reg;
   assign amp_gain_o = gain_reg;
   assign conv_start_o = start_reg;
   assign rd_data_o = rd_data;
   assign overrun_o = ovr_reg;

   // channel map: 0 amp, 1-7 external, 0x1C unused, rest internal

   property p_hold_on_accept;
      @(posedge clk_i) disable iff (rst_i)
      accept && st_reg == fas_pkg::FAS_IDLE |=> sample_hold_o && conv_start_o;
   endproperty
   a_hold_on_accept: assert property (p_hold_on_accept) else $error("no hold on command");

   property p_pair_both;
      @(posedge clk_i) disable iff (rst_i)
      accept && st_reg == fas_pkg::FAS_IDLE && cmd.pair |=> hold_stage_o == 2'h3;
   endproperty
   a_pair_both: assert property (p_pair_both) else $error("pair not held together");

   property p_pair_second;
      @(posedge clk_i) disable iff (rst_i)
      st_reg == fas_pkg::FAS_CONV_A && conv_done_i && push_ready && cur_reg.pair
      |=> conv_start_o && mux_sel_o == cur_reg.chan_b;
   endproperty
   a_pair_second: assert property (p_pair_second) else $error("second not converted");

   property p_mux_sel;
      @(posedge clk_i) disable iff (rst_i)
      accept && st_reg == fas_pkg::FAS_IDLE |=> mux_sel_o == $past(cmd.chan_a);
   endproperty
   a_mux_sel: assert property (p_mux_sel) else $error("mux select wrong");

   property p_gain_legal;
      @(posedge clk_i) disable iff (rst_i)
      amp_gain_o != 2'h3;
   endproperty
   a_gain_legal: assert property (p_gain_legal) else $error("illegal gain");

   property p_link_rise;
      @(posedge clk_i) disable iff (rst_i)
      !cs_s_reg[1] && link_rise |=> link_dout_o == $past(tx_reg[fas_pkg::RESULT_W-1]);
   endproperty
   a_link_rise: assert property (p_link_rise) else $error("dout not on rise");

   property p_shadow_stable;
      @(posedge clk_i) disable iff (rst_i)
      !frame_edge ##1 $stable(rd_addr_i) |=> $stable(rd_data_o);
   endproperty
   a_shadow_stable: assert property (p_shadow_stable) else $error("shadow changed");

   property p_slot_range;
      @(posedge clk_i) disable iff (rst_i)
      cmd_stb_reg && cmd.slot == 6'h3F |=> !sample_hold_o;
   endproperty
   a_slot_range: assert property (p_slot_range) else $error("slot 63 accepted");

   property p_overrun;
      @(posedge clk_i) disable iff (rst_i)
      cmd_stb_reg && st_reg != fas_pkg::FAS_IDLE |=> overrun_o;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun lost");
endmodule

// [tb/fas_link_ctrl.sv]
// controller end of the serial command link
`timescale 1ns/1ps
module fas_link_ctrl (
   output logic link_clk_o,
   output logic link_cs_n_o,
   output logic link_din_o,
   input wire logic link_dout_i,
   output logic [11:0] rx_word_o
);
   initial begin
      link_clk_o = 1'b0;
      link_cs_n_o = 1'b1;
      link_din_o = 1'b0;
      rx_word_o = 12'h000;
   end

   // clock runs only inside a frame, 400 ns period; instant set by caller
   task automatic send(input fas_pkg::fas_cmd_s cmd);
      logic [fas_pkg::CMD_W-1:0] w;
      w = cmd;
      #13;
      link_cs_n_o = 1'b0;
      for (int i = fas_pkg::CMD_W - 1; i >= 0; i--) begin
         link_din_o = w[i];
         #200;
         link_clk_o = 1'b1;
         // each rise returns the bit launched at the one before; keep the 12 result bits
         if (i <= fas_pkg::CMD_W - 2 && i >= fas_pkg::CMD_W - 13) begin
            rx_word_o = {rx_word_o[10:0], link_dout_i};
         end
         #200;
         link_clk_o = 1'b0;
      end
      link_cs_n_o = 1'b1;
      // released line must not look like a held bit
      link_din_o = ~link_din_o;
   endtask
endmodule

// [tb/test_fas_sampler.sv]
// self-checking bench for the converter sampler
`timescale 1ns/1ps
module test_fas_sampler;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic lclk, lcs_n, ldin, ldout;
   logic frame_start_i = 1'b0;
   logic sample_hold_o, conv_start_o, overrun_o;
   logic conv_done_i = 1'b0;
   logic [1:0] hold_stage_o, amp_gain_o;
   logic [4:0] mux_sel_o;
   logic [11:0] rd_data_o, s0, rx_word;
   logic [11:0] conv_data_i = 12'hFFF;
   logic [11:0] conv_val = 12'h5A3;
   logic [5:0] rd_addr_i = 6'h00;
   int err_count = 0;
   int check_count = 0;
   int conv_lat = 6;
   int cnt = 0;

   always #25 clk_i = ~clk_i;

   fas_link_ctrl i_fas_link_ctrl (.link_clk_o(lclk), .link_cs_n_o(lcs_n),
      .link_din_o(ldin), .link_dout_i(ldout), .rx_word_o(rx_word));

   fas_sampler i_fas_sampler (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(lclk),
      .link_cs_n_i(lcs_n), .link_din_i(ldin), .link_dout_o(ldout),
      .frame_start_i(frame_start_i), .sample_hold_o(sample_hold_o),
      .hold_stage_o(hold_stage_o), .mux_sel_o(mux_sel_o), .amp_gain_o(amp_gain_o),
      .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
      .conv_data_i(conv_data_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
      .overrun_o(overrun_o));

   // converter stand-in: one done pulse conv_lat cycles after each start
   always @(posedge clk_i) begin
      if (conv_start_o === 1'b1) cnt = conv_lat;
      else if (cnt != 0) cnt = cnt - 1;
      #5;
      conv_done_i = (cnt == 1);
      conv_data_i = (cnt == 1) ? conv_val : ~conv_val;
      if (cnt == 1) conv_val = conv_val + 12'h111;
   end

   task chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task end_of_test();
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask

   // send a command and judge the sampling pulse it should cause
   task issue(input fas_pkg::fas_cmd_s c, input logic hit);
      int n;
      n = 0;
      fork
         i_fas_link_ctrl.send(c);
         while (sample_hold_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
         end
      join
      chk(12'(sample_hold_o), 12'(hit));
      if (hit) begin
         chk(12'(mux_sel_o), 12'(c.chan_a));
         chk(12'(hold_stage_o), 12'({c.pair, 1'b1}));
         chk(12'(conv_start_o), 12'h001);
         if (c.chan_a == fas_pkg::CH_CURRENT_AMP) chk(12'(amp_gain_o), 12'(c.gain));
      end
      cyc(1);
   endtask

   task drain();
      int n;
      n = 0;
      while (hold_stage_o !== 2'h0 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk(12'(hold_stage_o), 12'h000);
      cyc(8);
   endtask

   task frame();
      frame_start_i = 1'b1;
      cyc(4);
      frame_start_i = 1'b0;
      cyc(4);
   endtask

   task rd(input logic [5:0] a, input logic [11:0] exp);
      rd_addr_i = a;
      cyc(1);
      chk(rd_data_o, exp);
   endtask

   task t_reset();
      chk(12'({sample_hold_o, conv_start_o, overrun_o, hold_stage_o}), 12'h000);
      chk(12'(mux_sel_o), 12'h000);
      chk(12'(amp_gain_o), 12'(fas_pkg::GAIN_RESET));
      rd(6'h00, fas_pkg::RESULT_RESET);
      $display("reset test done");
   endtask

   // current amp at every gain, an external pin, an internal source
   task t_single();
      logic [11:0] v [5];
      logic [4:0] ch [5];
      logic [5:0] sl [5];
      logic [1:0] g [5];
      ch = '{5'h00, 5'h00, 5'h00, fas_pkg::CH_EXT_LAST, 5'h1D};
      sl = '{6'h00, 6'h01, 6'h02, 6'h3E, 6'h03};
      g = '{fas_pkg::GAIN_24X, fas_pkg::GAIN_12X, fas_pkg::GAIN_9X, 2'h0, 2'h0};
      for (int k = 0; k < 5; k++) begin
         v[k] = conv_val;
         issue('{1'b0, sl[k], ch[k], 5'h00, g[k]}, 1'b1);
         drain();
      end
      rd(6'h00, 12'h000);
      frame();
      for (int k = 0; k < 5; k++) rd(sl[k], v[k]);
      rd(6'h3F, 12'h000);
      s0 = v[0];
      $display("single sample test done");
   endtask

   task t_pair();
      logic [11:0] a;
      logic [11:0] b;
      int n;
      a = conv_val;
      b = conv_val + 12'h111;
      issue('{1'b1, 6'h1E, fas_pkg::CH_CURRENT_AMP, 5'h03, fas_pkg::GAIN_9X}, 1'b1);
      n = 0;
      while (conv_start_o !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk(12'(conv_start_o), 12'h001);
      drain();
      // slot 63 is out of range and must not sample
      issue('{1'b0, 6'h3F, 5'h01, 5'h00, 2'h0}, 1'b0);
      frame();
      rd(6'h1E, a);
      rd(6'h1F, b);
      rd(6'h00, s0);
      $display("pair test done");
   endtask

   // second command lands while the first is still converting
   task t_overrun();
      logic [11:0] v;
      conv_lat = 1000;
      v = conv_val;
      issue('{1'b0, 6'h28, 5'h02, 5'h00, 2'h0}, 1'b1);
      chk(rx_word, s0);
      issue('{1'b0, 6'h29, 5'h05, 5'h00, 2'h0}, 1'b0);
      chk(12'(overrun_o), 12'h001);
      drain();
      conv_lat = 6;
      frame();
      chk(12'(overrun_o), 12'h000);
      rd(6'h28, v);
      rd(6'h29, 12'h000);
      $display("overrun test done");
   endtask

   initial begin
      #3000000;
      err_count++;
      end_of_test();
   end

   initial begin
      repeat (20) @(posedge clk_i);
      #5;
      rst_i = 1'b0;
      cyc(1);
      t_reset();
      t_single();
      t_pair();
      t_overrun();
      end_of_test();
   end
endmodule
